// [common/tcio_pkg.sv]
package tcio_pkg;

    // register byte offsets on the bus
    localparam logic [7:0] OFS_CTRL_HIGH = 8'h00;
    localparam logic [7:0] OFS_CTRL_LOW = 8'h04;
    localparam logic [7:0] OFS_MODE = 8'h08;
    localparam logic [7:0] OFS_GR_A = 8'h0C;
    localparam logic [7:0] OFS_GR_B = 8'h10;
    localparam logic [7:0] OFS_GR_C = 8'h14;
    localparam logic [7:0] OFS_GR_D = 8'h18;
    localparam logic [7:0] OFS_PIN_STATUS = 8'h1C;

    // field layout of the control registers
    localparam int unsigned FIELD_W = 4;
    localparam int unsigned FIELD_HI_LSB = 4;
    localparam int unsigned FIELD_LO_LSB = 0;
    localparam int unsigned FIELD_CAP_BIT = 3;
    localparam int unsigned FIELD_INIT_BIT = 2;

    // mode register layout
    localparam int unsigned BUF_B_BIT = 5;
    localparam int unsigned BUF_A_BIT = 4;
    localparam logic [7:0] MODE_FIXED_ONES = 8'hC0;
    localparam logic [3:0] MODE_MD_RESET = 4'h0;

    // reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [1:0] BUF_RESET = 2'h0;
    localparam logic [15:0] GR_RESET = 16'h0000;

    // general register indices
    localparam int unsigned IDX_A = 0;
    localparam int unsigned IDX_B = 1;
    localparam int unsigned IDX_C = 2;
    localparam int unsigned IDX_D = 3;

    // function selected by one 4-bit field
    typedef enum logic [2:0] {
        TCIO_OUT_OFF = 3'b000,
        TCIO_OUT_LOW = 3'b001,
        TCIO_OUT_HIGH = 3'b010,
        TCIO_OUT_TOGGLE = 3'b011,
        TCIO_CAP_RISE = 3'b100,
        TCIO_CAP_FALL = 3'b101,
        TCIO_CAP_BOTH = 3'b110,
        TCIO_CAP_CH1 = 3'b111
    } tcio_mode_e;

    // field code to function
    function automatic tcio_mode_e tcio_decode(input logic [3:0] f);
        tcio_mode_e m;
        m = TCIO_OUT_OFF;
        if (!f[3]) begin
            case (f[1:0])
                2'h1: m = TCIO_OUT_LOW;
                2'h2: m = TCIO_OUT_HIGH;
                2'h3: m = TCIO_OUT_TOGGLE;
                default: m = TCIO_OUT_OFF;
            endcase
        end else if (f[2]) begin
            m = TCIO_CAP_CH1;
        end else begin
            case (f[1:0])
                2'h0: m = TCIO_CAP_RISE;
                2'h1: m = TCIO_CAP_FALL;
                default: m = TCIO_CAP_BOTH;
            endcase
        end
        return m;
    endfunction

endpackage

// [src/tcio_chan.sv]
`timescale 1ns/100ps
module tcio_chan #(
    parameter int unsigned GR_W = 16
) (
    // clock and control
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ce,
    // configuration
    input wire logic [3:0] field,
    input wire logic active,
    // events and values
    input wire logic pin_sync,
    input wire logic cnt_tick,
    input wire logic ch1_tick,
    input wire logic [GR_W-1:0] cnt_value,
    input wire logic [GR_W-1:0] gr_value,
    // results
    output logic cap_hit,
    output logic match_hit,
    output logic pin_out,
    output logic pin_oe
);

    typedef struct packed {
        logic pin_prev;
        logic pin_out;
        logic pin_oe;
        logic [4:0] cfg_prev;
    } tcio_chan_s;

    tcio_chan_s st_q;
    tcio_chan_s st_d;
    tcio_pkg::tcio_mode_e mode;
    logic rise;
    logic fall;

    assign pin_out = st_q.pin_out;
    assign pin_oe = st_q.pin_oe;

    // capture, compare and pin level
    always_comb begin
        st_d = st_q;
        mode = tcio_pkg::tcio_decode(field);
        rise = pin_sync & ~st_q.pin_prev;
        fall = ~pin_sync & st_q.pin_prev;
        st_d.pin_prev = pin_sync;
        st_d.cfg_prev = {active, field};
        cap_hit = 1'b0;
        case (mode)
            tcio_pkg::TCIO_CAP_RISE: cap_hit = rise; // see RQ7
            tcio_pkg::TCIO_CAP_FALL: cap_hit = fall; // see RQ8
            tcio_pkg::TCIO_CAP_BOTH: cap_hit = rise | fall; // see RQ9
            tcio_pkg::TCIO_CAP_CH1: cap_hit = ch1_tick; // see RQ12
            default: cap_hit = 1'b0;
        endcase
        cap_hit = cap_hit & active; // see RQ14
        match_hit = active & ~field[tcio_pkg::FIELD_CAP_BIT] & cnt_tick
            & (cnt_value == gr_value); // see RQ3
        // output enable only for driving output codes
        st_d.pin_oe = active & ~field[tcio_pkg::FIELD_CAP_BIT]
            & (field[1:0] != 2'h0); // see RQ3
        if ({active, field} != st_q.cfg_prev) begin
            st_d.pin_out = field[tcio_pkg::FIELD_INIT_BIT]; // see RQ3
        end else if (match_hit) begin
            case (mode)
                tcio_pkg::TCIO_OUT_LOW: st_d.pin_out = 1'b0; // see RQ4
                tcio_pkg::TCIO_OUT_HIGH: st_d.pin_out = 1'b1; // see RQ5
                tcio_pkg::TCIO_OUT_TOGGLE: st_d.pin_out = ~st_q.pin_out; // see RQ6
                default: st_d.pin_out = st_q.pin_out;
            endcase
        end
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_q <= '0;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

endmodule

// [src/tcio_top.sv]
// What this block does
// (RQ1) The high control register holds register B's function in bits 7-4 and A's in 3-0.
// (RQ2) The low control register holds register D's function in bits 7-4 and C's in 3-0.
// (RQ3) Top bit 0 means output compare; low bits 00 disable the pin, bit 2 is the first level.
// (RQ4) Low bits 01 drive the pin low on each compare match after the first level.
// (RQ5) Low bits 10 drive the pin high on each compare match.
// (RQ6) Low bits 11 invert the pin on each compare match.
// (RQ7) Code 1000 captures the counter on a rising pin edge.
// (RQ8) Code 1001 captures the counter on a falling pin edge.
// (RQ9) Codes 1010 and 1011 capture the counter on both pin edges.
// (RQ10) With buffer B on, register D's field is ignored and D neither captures nor compares.
// (RQ11) With buffer A on, register C's field is ignored and C neither captures nor compares.
// (RQ12) Codes 11xx capture the counter on each count of channel 1.
// (RQ13) Both control registers clear on power-on reset or standby and keep their value otherwise.
// (RQ14) A register used as a buffer makes no capture and no compare of its own.
`timescale 1ns/100ps
module tcio_top #(
    parameter int unsigned GR_W = 16
) (
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic standby,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // counter side
    input wire logic [GR_W-1:0] cnt_value,
    input wire logic cnt_tick,
    input wire logic ch1_tick,
    // pin a
    input wire logic pin_a_in,
    output logic pin_a_out,
    output logic pin_a_oe,
    // pin b
    input wire logic pin_b_in,
    output logic pin_b_out,
    output logic pin_b_oe,
    // pin c
    input wire logic pin_c_in,
    output logic pin_c_out,
    output logic pin_c_oe,
    // pin d
    input wire logic pin_d_in,
    output logic pin_d_out,
    output logic pin_d_oe,
    // event pulses, index 0 = a
    output logic [3:0] capture_evt,
    output logic [3:0] match_evt
);

    typedef struct packed {
        logic [7:0] ctrl_high;
        logic [7:0] ctrl_low;
        logic [1:0] buf_en;
        logic [3:0] md;
        logic [3:0][GR_W-1:0] gr;
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [3:0] cap_evt;
        logic [3:0] match_evt;
    } tcio_state_s;

    tcio_state_s st_q;
    tcio_state_s st_d;
    logic [3:0][3:0] field;
    logic [3:0] active;
    logic [3:0] cap_hit;
    logic [3:0] match_hit;
    logic [3:0] pin_out;
    logic [3:0] pin_oe;
    logic [3:0] pin_raw;
    logic acc;
    logic commit;
    logic [31:0] rd_word;

    // true for every mapped register offset
    function automatic logic addr_mapped(input logic [7:0] a);
        logic ok;
        ok = 1'b0;
        case (a)
            tcio_pkg::OFS_CTRL_HIGH,
            tcio_pkg::OFS_CTRL_LOW,
            tcio_pkg::OFS_MODE,
            tcio_pkg::OFS_GR_A,
            tcio_pkg::OFS_GR_B,
            tcio_pkg::OFS_GR_C,
            tcio_pkg::OFS_GR_D,
            tcio_pkg::OFS_PIN_STATUS: ok = 1'b1;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    // widen a general register to a bus word
    function automatic logic [31:0] gr_word(input logic [GR_W-1:0] v);
        logic [31:0] w;
        w = '0;
        w[GR_W-1:0] = v;
        return w;
    endfunction

    // pin bundle
    assign pin_raw = {pin_d_in, pin_c_in, pin_b_in, pin_a_in};

    // fields of the four general registers
    assign field[tcio_pkg::IDX_A] =
        st_q.ctrl_high[tcio_pkg::FIELD_LO_LSB +: tcio_pkg::FIELD_W]; // see RQ1
    assign field[tcio_pkg::IDX_B] =
        st_q.ctrl_high[tcio_pkg::FIELD_HI_LSB +: tcio_pkg::FIELD_W]; // see RQ1
    assign field[tcio_pkg::IDX_C] =
        st_q.ctrl_low[tcio_pkg::FIELD_LO_LSB +: tcio_pkg::FIELD_W]; // see RQ2
    assign field[tcio_pkg::IDX_D] =
        st_q.ctrl_low[tcio_pkg::FIELD_HI_LSB +: tcio_pkg::FIELD_W]; // see RQ2

    // buffer partners lose their own function
    assign active[tcio_pkg::IDX_A] = 1'b1;
    assign active[tcio_pkg::IDX_B] = 1'b1;
    assign active[tcio_pkg::IDX_C] = ~st_q.buf_en[0]; // see RQ11
    assign active[tcio_pkg::IDX_D] = ~st_q.buf_en[1]; // see RQ10

    // one channel unit per general register
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_chan
            tcio_chan #(
                .GR_W(GR_W)
            ) u_chan (
                .sys_clk(sys_clk),
                .rst_n(rst_n),
                .ce(ce),
                .field(field[gi]),
                .active(active[gi]),
                .pin_sync(st_q.sync2[gi]),
                .cnt_tick(cnt_tick),
                .ch1_tick(ch1_tick),
                .cnt_value(cnt_value),
                .gr_value(st_q.gr[gi]),
                .cap_hit(cap_hit[gi]),
                .match_hit(match_hit[gi]),
                .pin_out(pin_out[gi]),
                .pin_oe(pin_oe[gi])
            );
        end
    endgenerate

    // pin outputs straight from channel flops
    assign pin_a_out = pin_out[tcio_pkg::IDX_A];
    assign pin_b_out = pin_out[tcio_pkg::IDX_B];
    assign pin_c_out = pin_out[tcio_pkg::IDX_C];
    assign pin_d_out = pin_out[tcio_pkg::IDX_D];
    assign pin_a_oe = pin_oe[tcio_pkg::IDX_A];
    assign pin_b_oe = pin_oe[tcio_pkg::IDX_B];
    assign pin_c_oe = pin_oe[tcio_pkg::IDX_C];
    assign pin_d_oe = pin_oe[tcio_pkg::IDX_D];

    // bus and event outputs
    assign prdata = st_q.prdata;
    assign pready = st_q.pready;
    assign pslverr = st_q.pslverr;
    assign capture_evt = st_q.cap_evt;
    assign match_evt = st_q.match_evt;

    // access phase and the edge that completes it
    assign acc = psel & penable;
    assign commit = acc & st_q.pready & pwrite & ~st_q.pslverr;

    // read mux
    always_comb begin
        rd_word = '0;
        case (paddr)
            tcio_pkg::OFS_CTRL_HIGH: rd_word[7:0] = st_q.ctrl_high;
            tcio_pkg::OFS_CTRL_LOW: rd_word[7:0] = st_q.ctrl_low;
            tcio_pkg::OFS_MODE: begin
                rd_word[7:0] = tcio_pkg::MODE_FIXED_ONES;
                rd_word[tcio_pkg::BUF_B_BIT] = st_q.buf_en[1];
                rd_word[tcio_pkg::BUF_A_BIT] = st_q.buf_en[0];
                rd_word[3:0] = st_q.md;
            end
            tcio_pkg::OFS_GR_A: rd_word = gr_word(st_q.gr[tcio_pkg::IDX_A]);
            tcio_pkg::OFS_GR_B: rd_word = gr_word(st_q.gr[tcio_pkg::IDX_B]);
            tcio_pkg::OFS_GR_C: rd_word = gr_word(st_q.gr[tcio_pkg::IDX_C]);
            tcio_pkg::OFS_GR_D: rd_word = gr_word(st_q.gr[tcio_pkg::IDX_D]);
            tcio_pkg::OFS_PIN_STATUS: begin
                rd_word[3:0] = st_q.sync2;
                rd_word[7:4] = pin_out;
                rd_word[11:8] = pin_oe;
            end
            default: rd_word = '0;
        endcase
    end

    // next state
    always_comb begin
        st_d = st_q;
        // two-stage pin synchroniser
        st_d.sync1 = pin_raw;
        st_d.sync2 = st_q.sync1;
        // bus answer one cycle into the access phase
        st_d.pready = acc & ~st_q.pready;
        if (acc && !st_q.pready) begin
            st_d.pslverr = ~addr_mapped(paddr);
            st_d.prdata = pwrite ? 32'h0000_0000 : rd_word;
        end else begin
            st_d.pslverr = 1'b0;
        end
        // software writes
        if (commit) begin
            case (paddr)
                tcio_pkg::OFS_CTRL_HIGH: st_d.ctrl_high = pwdata[7:0];
                tcio_pkg::OFS_CTRL_LOW: st_d.ctrl_low = pwdata[7:0];
                tcio_pkg::OFS_MODE: begin
                    st_d.buf_en[1] = pwdata[tcio_pkg::BUF_B_BIT];
                    st_d.buf_en[0] = pwdata[tcio_pkg::BUF_A_BIT];
                    st_d.md = pwdata[3:0];
                end
                tcio_pkg::OFS_GR_A: st_d.gr[tcio_pkg::IDX_A] = pwdata[GR_W-1:0];
                tcio_pkg::OFS_GR_B: st_d.gr[tcio_pkg::IDX_B] = pwdata[GR_W-1:0];
                tcio_pkg::OFS_GR_C: st_d.gr[tcio_pkg::IDX_C] = pwdata[GR_W-1:0];
                tcio_pkg::OFS_GR_D: st_d.gr[tcio_pkg::IDX_D] = pwdata[GR_W-1:0];
                default: st_d.gr = st_q.gr;
            endcase
        end
        // capture wins over a write in the same cycle
        for (int i = 0; i < 4; i++) begin
            if (cap_hit[i]) begin
                st_d.gr[i] = cnt_value; // see RQ7
            end
        end
        // buffer pairs: capture pushes old value down, match pulls new one up
        if (st_q.buf_en[0]) begin
            if (cap_hit[tcio_pkg::IDX_A]) begin
                st_d.gr[tcio_pkg::IDX_C] = st_q.gr[tcio_pkg::IDX_A]; // see RQ11
            end else if (match_hit[tcio_pkg::IDX_A]) begin
                st_d.gr[tcio_pkg::IDX_A] = st_q.gr[tcio_pkg::IDX_C];
            end
        end
        if (st_q.buf_en[1]) begin
            if (cap_hit[tcio_pkg::IDX_B]) begin
                st_d.gr[tcio_pkg::IDX_D] = st_q.gr[tcio_pkg::IDX_B]; // see RQ10
            end else if (match_hit[tcio_pkg::IDX_B]) begin
                st_d.gr[tcio_pkg::IDX_B] = st_q.gr[tcio_pkg::IDX_D];
            end
        end
        // one-cycle event pulses
        st_d.cap_evt = cap_hit;
        st_d.match_evt = match_hit;
        // standby clears the control registers
        if (standby) begin
            st_d.ctrl_high = tcio_pkg::CTRL_RESET; // see RQ13
            st_d.ctrl_low = tcio_pkg::CTRL_RESET; // see RQ13
            st_d.buf_en = tcio_pkg::BUF_RESET;
            st_d.md = tcio_pkg::MODE_MD_RESET;
        end
    end

    // state register, power-on reset
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_q <= '0; // see RQ13
        end else if (ce) begin
            st_q <= st_d;
        end
    end

endmodule

// [tb/tcio_properties.sv]
`timescale 1ns/100ps
module tcio_properties (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic standby,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // watched outputs
    input wire logic pin_a_out,
    input wire logic pin_a_oe,
    input wire logic pin_c_oe,
    input wire logic [3:0] capture_evt,
    input wire logic [3:0] match_evt
);
    typedef struct packed {
        logic [7:0] hi;
        logic [7:0] lo;
        logic [1:0] bf;
    } tcio_shadow_s;
    tcio_shadow_s sh_q;
    tcio_shadow_s sh_d;
    logic wr_en;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // committed apb write
    assign wr_en = psel && penable && pready && pwrite && !pslverr;

    // shadow of control fields and buffer bits
    always_comb begin
        sh_d = sh_q;
        if (wr_en && paddr == tcio_pkg::OFS_CTRL_HIGH) sh_d.hi = pwdata[7:0];
        if (wr_en && paddr == tcio_pkg::OFS_CTRL_LOW) sh_d.lo = pwdata[7:0];
        if (wr_en && paddr == tcio_pkg::OFS_MODE) sh_d.bf = pwdata[5:4];
        if (standby || !rst_n) sh_d = '0;
    end

    // shadow register
    always_ff @(posedge sys_clk) begin
        sh_q <= sh_d;
    end

    chk_oe_off: assert property (
        !sh_q.hi[3] && sh_q.hi[1:0] == 2'h0 && $stable(sh_q.hi) |-> !pin_a_oe
    ) else $error("pin a driven while off");
    chk_match_mode: assert property (
        match_evt[0] |-> !$past(sh_q.hi[3])
    ) else $error("match on a capture register");
    chk_cap_mode_b: assert property (
        capture_evt[1] |-> $past(sh_q.hi[7])
    ) else $error("capture on b in output mode");
    chk_match_low: assert property (
        match_evt[0] && $past(sh_q.hi[1:0]) == 2'h1 |-> ##[0:1] !pin_a_out
    ) else $error("pin a not low after match");
    chk_match_high: assert property (
        match_evt[0] && $past(sh_q.hi[1:0]) == 2'h2 |-> ##[0:1] pin_a_out
    ) else $error("pin a not high after match");
    chk_buf_d_quiet: assert property (
        $past(sh_q.bf[1]) |-> !capture_evt[3] && !match_evt[3]
    ) else $error("buffer d made an event");
    chk_buf_c_off: assert property (
        sh_q.bf[0] && $past(sh_q.bf[0]) |-> !pin_c_oe && !capture_evt[2]
    ) else $error("buffer c active");
    chk_standby_clr: assert property (
        standby |-> ##2 !pin_a_oe
    ) else $error("standby left pin a driven");
endmodule

bind tcio_top tcio_properties u_chk (
    .sys_clk, .rst_n, .standby, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .pslverr, .pin_a_out, .pin_a_oe, .pin_c_oe, .capture_evt, .match_evt
);

// [tb/tcio_pin_model.sv]
`timescale 1ns/100ps
module tcio_pin_model (
    // pad side of the block
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe,
    // levels forced from outside
    input wire logic [3:0] ext_lvl,
    output logic [3:0] pin_in
);
    // block wins the wire while it drives
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule

// [tb/tcio_top_tb.sv]
`timescale 1ns/100ps
module tcio_top_tb;
    logic sys_clk, rst_n, standby, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] cnt_value;
    logic cnt_tick, ch1_tick;
    logic [3:0] ext, p_in, p_out, p_oe, capture_evt, match_evt;
    int fails, samples_checked;
    int ncap [4];
    int nmat [4];

    tcio_top #(.GR_W(16)) u_dut (
        .sys_clk, .rst_n, .ce(1'b1), .standby,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .cnt_value, .cnt_tick, .ch1_tick,
        .pin_a_in(p_in[0]), .pin_a_out(p_out[0]), .pin_a_oe(p_oe[0]),
        .pin_b_in(p_in[1]), .pin_b_out(p_out[1]), .pin_b_oe(p_oe[1]),
        .pin_c_in(p_in[2]), .pin_c_out(p_out[2]), .pin_c_oe(p_oe[2]),
        .pin_d_in(p_in[3]), .pin_d_out(p_out[3]), .pin_d_oe(p_oe[3]),
        .capture_evt, .match_evt
    );
    tcio_pin_model u_pins (.pin_out(p_out), .pin_oe(p_oe), .ext_lvl(ext), .pin_in(p_in));

    // clock
    always #2.5 sys_clk = ~sys_clk;

    // event counters
    always @(posedge sys_clk) begin
        for (int i = 0; i < 4; i++) begin
            ncap[i] += capture_evt[i];
            nmat[i] += match_evt[i];
        end
    end

    task automatic stop_test;
        if (fails == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        samples_checked++;
        if (s !== x) begin
            fails++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, x);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // one apb transfer, entered right after an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // wait for the answer; only the watchdog ends a hang
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // idle edge so a following setup never re-raises psel in this step
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, x);
    endtask

    task automatic pulse(input bit ch1);
        if (ch1) ch1_tick <= 1'b1;
        else cnt_tick <= 1'b1;
        @(posedge sys_clk);
        ch1_tick <= 1'b0;
        cnt_tick <= 1'b0;
    endtask

    // reset values, field placement, unmapped access, standby clear
    task automatic t_regs;
        logic [31:0] r;
        logic e;
        rd_chk(tcio_pkg::OFS_CTRL_HIGH, 32'h0);
        rd_chk(tcio_pkg::OFS_CTRL_LOW, 32'h0);
        wr(tcio_pkg::OFS_CTRL_HIGH, 32'hFFFF_FFA5);
        wr(tcio_pkg::OFS_CTRL_LOW, 32'h5A);
        wr(tcio_pkg::OFS_MODE, 32'h3F);
        rd_chk(tcio_pkg::OFS_CTRL_HIGH, 32'hA5);
        rd_chk(tcio_pkg::OFS_CTRL_LOW, 32'h5A);
        apb(1'b1, 8'h40, 32'h1, r, e);
        chk(e, 1'b1);
        standby <= 1'b1;
        @(posedge sys_clk);
        standby <= 1'b0;
        cyc(2);
        rd_chk(tcio_pkg::OFS_CTRL_HIGH, 32'h0);
        rd_chk(tcio_pkg::OFS_CTRL_LOW, 32'h0);
        rd_chk(tcio_pkg::OFS_MODE, 32'hC0);
    endtask

    // every output code on register a, then one compare match
    task automatic t_out;
        logic [3:0] c;
        wr(tcio_pkg::OFS_GR_A, 32'h5);
        cnt_value <= 16'h5;
        for (int i = 0; i < 8; i++) begin
            c = i[3:0];
            wr(tcio_pkg::OFS_CTRL_HIGH, {28'h0, c});
            cyc(3);
            chk(p_oe[0], c[1:0] != 2'h0);
            if (c[1:0] != 2'h0) chk(p_out[0], c[2]);
            nmat[0] = 0;
            pulse(1'b0);
            cyc(3);
            chk(nmat[0], 1);
            if (c[1:0] != 2'h0) chk(p_out[0], c[1] & ~(c[0] & c[2]));
        end
    endtask

    // capture codes on register b: pin edges and channel 1 counts
    task automatic t_cap;
        logic [3:0] c;
        logic rs, fl;
        cnt_value <= 16'h1234;
        for (int i = 8; i < 13; i++) begin
            c = i[3:0];
            rs = !c[2] && (c[1] || !c[0]);
            fl = !c[2] && (c[1] || c[0]);
            wr(tcio_pkg::OFS_CTRL_HIGH, {24'h0, c, 4'h0});
            cyc(8);
            chk(p_oe[1], 1'b0);
            ncap[1] = 0;
            ext[1] <= 1'b1;
            cyc(8);
            chk(ncap[1], rs);
            ext[1] <= 1'b0;
            cyc(8);
            chk(ncap[1], rs + fl);
            if (c[2]) pulse(1'b1);
            cyc(4);
            if (c[2]) chk(ncap[1], 1);
        end
        rd_chk(tcio_pkg::OFS_GR_B, 32'h1234);
    endtask

    // buffered c and d stay silent, c comes back when released
    task automatic t_buf;
        wr(tcio_pkg::OFS_MODE, 32'h30);
        wr(tcio_pkg::OFS_CTRL_LOW, 32'h83);
        wr(tcio_pkg::OFS_GR_C, 32'h5);
        cnt_value <= 16'h5;
        cyc(8);
        ncap = '{0, 0, 0, 0};
        nmat = '{0, 0, 0, 0};
        ext[3] <= 1'b1;
        pulse(1'b0);
        cyc(8);
        chk(p_oe[2], 1'b0);
        chk(nmat[2], 0);
        chk(ncap[3], 0);
        wr(tcio_pkg::OFS_MODE, 32'h0);
        cyc(3);
        chk(p_oe[2], 1'b1);
        chk(p_out[2], 1'b0);
        chk(p_oe[3], 1'b0);
        // d is live again: a fresh rising edge must capture
        ext[3] <= 1'b0;
        cyc(8);
        ncap[3] = 0;
        ext[3] <= 1'b1;
        cyc(8);
        chk(ncap[3], 1);
        rd_chk(tcio_pkg::OFS_GR_D, 32'h5);
    endtask

    // watchdog
    initial begin
        #50000;
        fails++;
        stop_test;
    end

    // main sequence
    initial begin
        sys_clk = 1'b0;
        rst_n = 1'b0;
        standby = 1'b0;
        {psel, penable, pwrite} = 3'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        cnt_value = 16'h0;
        {cnt_tick, ch1_tick} = 2'h0;
        ext = 4'h0;
        fails = 0;
        samples_checked = 0;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        t_regs;
        t_out;
        t_cap;
        t_buf;
        stop_test;
    end
endmodule
